// [common/svd_pkg.sv]
// package for the supply voltage detect controller
// assumes an axi4-lite register bus with 32-bit data and one aligned word per register
package svd_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;  // voltage_detect_control
  localparam logic [7:0] OFS_INTERRUPT_CONTROL_MAIN = 8'h04;   // interrupt_control_main
  localparam logic [7:0] OFS_FLAGS = 8'h08;    // peripheral_irq_flags_two
  localparam logic [7:0] OFS_ENABLES = 8'h0C;  // peripheral_irq_enables_two
  localparam logic [7:0] OFS_PRIORITY = 8'h10; // peripheral_irq_priority_two
  localparam logic [7:0] OFS_STATUS = 8'h14;   // sticky event status, clear on read
  localparam logic [7:0] OFS_MASK = 8'h18;     // event mask

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_DIR_BIT = 7;
  localparam int CTL_STABLE_BIT = 5;
  localparam int CTL_EN_BIT = 4;
  localparam int GIE_BIT = 7;
  localparam int DETECT_BIT = 2;
  localparam int EV_DETECT_BIT = 0;
  localparam int EV_STABLE_BIT = 1;

  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [7:0] CTL_RESET = 8'h05;
  localparam logic [7:0] CTL_WMASK = 8'h9F;  // bit 6 unimplemented, bit 5 read only
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SETTLE_US = 20;  // reference settle time, least value
  localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1_000_000));

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic dir;
    logic en;
    logic [3:0] level;
  } svd_cfg_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic [1:0] resp;
  } svd_rd_t;

endpackage : svd_pkg

// [src/svd_ctrl.sv]
// supply voltage detect control logic with axi4-lite register slave
// assumes comparator outputs are asynchronous levels and the settle time is counted on aclk
//
// Contract
// - four-bit trip level select in control bits 3 to 0 picks sixteen levels
// - level select all ones routes comparator from external trip input
// - crossing in configured direction sets the detect flag
// - no detect interrupt before reference stable bit is set
// - detect flag held off until the settle interval expires
// - settle interval fixed in time, restarts on every re-enable of the reference
// - detector runs in sleep; crossing sets flag and wakes device
// - after wake, vector taken only when global interrupts enabled
// - reset returns all registers to reset values, detector off
// - direction clear trips on falling to set point, set on rising to it
// - reference stable bit is read only and set by hardware after enable
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module svd_ctrl #(
  parameter int SETTLE_CYCLES = svd_pkg::SETTLE_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end
  input wire logic cmp_below_internal,
  input wire logic cmp_below_external,
  output logic [3:0] trip_level_select,
  output logic external_trip_select,
  output logic detector_power,
  // system
  input wire logic sleep_active,
  output logic wake_request,
  output logic irq_vector_request,
  output logic irq
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  svd_pkg::svd_cfg_t cfg_q;
  logic reference_stable_q;
  logic detect_flag_q;
  logic [7:0] interrupt_control_main_q;
  logic [7:0] flags_other_q;
  logic [7:0] enables_q;
  logic [7:0] priority_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [7:0] ctl_rd;
  logic [7:0] flags_rd;

  // write channel holding
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [1:0] bresp_q;
  logic bvalid_q;

  // read channel
  svd_pkg::svd_rd_t rd_q;
  logic rd_fire;
  logic stat_read;

  // detect path
  logic cmp_sel;
  logic cmp_s1_q;
  logic cmp_s2_q;
  logic trip_now;
  logic [$clog2(SETTLE_CYCLES + 1) - 1:0] settle_cnt_q;
  logic stable_rise;
  logic detect_set;
  logic flag_clear;
  logic stat_clear_detect;

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  // each channel taken independently, response after both
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q;

  // address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
      end
    end
  end

  // write response, slverr on unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= svd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      unique case (awaddr_q)
        svd_pkg::OFS_CONTROL, svd_pkg::OFS_INTERRUPT_CONTROL_MAIN, svd_pkg::OFS_FLAGS,
        svd_pkg::OFS_ENABLES, svd_pkg::OFS_PRIORITY, svd_pkg::OFS_STATUS,
        svd_pkg::OFS_MASK: bresp_q <= svd_pkg::RESP_OKAY;
        default: bresp_q <= svd_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------
  // software writable registers
  // ----------------------------------------
  // only byte lane 0 carries the 8-bit registers
  // reset values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= svd_pkg::svd_cfg_t'({1'b0, svd_pkg::CTL_RESET[4:0]});
      interrupt_control_main_q <= svd_pkg::BYTE_RESET;
      flags_other_q <= svd_pkg::BYTE_RESET;
      enables_q <= svd_pkg::BYTE_RESET;
      priority_q <= svd_pkg::BYTE_RESET;
      mask_q <= 2'b00;
    end else if (wr_fire && wstrb_q[0]) begin
      unique case (awaddr_q)
        svd_pkg::OFS_CONTROL: begin
          cfg_q.dir <= wdata_q[svd_pkg::CTL_DIR_BIT];
          cfg_q.en <= wdata_q[svd_pkg::CTL_EN_BIT];
          cfg_q.level <= wdata_q[3:0];
        end
        svd_pkg::OFS_INTERRUPT_CONTROL_MAIN: interrupt_control_main_q <= wdata_q[7:0];
        svd_pkg::OFS_FLAGS: flags_other_q <= wdata_q[7:0] & ~(8'h01 << svd_pkg::DETECT_BIT);
        svd_pkg::OFS_ENABLES: enables_q <= wdata_q[7:0];
        svd_pkg::OFS_PRIORITY: priority_q <= wdata_q[7:0];
        svd_pkg::OFS_MASK: mask_q <= wdata_q[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // comparator path
  // ----------------------------------------
  // external input on all-ones level
  assign external_trip_select = (cfg_q.level == svd_pkg::LEVEL_EXTERNAL);
  assign cmp_sel = external_trip_select ? cmp_below_external : cmp_below_internal;
  assign trip_level_select = cfg_q.level;
  assign detector_power = cfg_q.en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_sel;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // direction: low means at or below, high means above
  assign trip_now = cfg_q.dir ? !cmp_s2_q : cmp_s2_q;

  // ----------------------------------------
  // reference settle timer
  // ----------------------------------------
  // fixed time count, restarts when enable drops
  // stable bit set by hardware only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_q <= '0;
      reference_stable_q <= 1'b0;
    end else if (!cfg_q.en) begin
      settle_cnt_q <= '0;
      reference_stable_q <= 1'b0;
    end else if (!reference_stable_q) begin
      if (settle_cnt_q == ($bits(settle_cnt_q))'(SETTLE_CYCLES - 1)) begin
        reference_stable_q <= 1'b1;
      end else begin
        settle_cnt_q <= settle_cnt_q + 1'b1;
      end
    end
  end

  assign stable_rise = cfg_q.en && !reference_stable_q &&
                       (settle_cnt_q == ($bits(settle_cnt_q))'(SETTLE_CYCLES - 1));

  // ----------------------------------------
  // detect flag
  // ----------------------------------------
  // gated by stable, set also while asleep
  assign detect_set = cfg_q.en && reference_stable_q && trip_now;
  assign flag_clear = wr_fire && wstrb_q[0] && (awaddr_q == svd_pkg::OFS_FLAGS) &&
                      !wdata_q[svd_pkg::DETECT_BIT];

  // sticky flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_flag_q <= 1'b0;
    end else if (detect_set) begin
      detect_flag_q <= 1'b1;
    end else if (flag_clear) begin
      detect_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupt status and outputs
  // ----------------------------------------
  assign stat_read = rd_fire && (s_axi_araddr == svd_pkg::OFS_STATUS);
  assign stat_clear_detect = stat_read;

  // sticky events, cleared by reading, new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 2'b00;
    end else begin
      status_q[svd_pkg::EV_DETECT_BIT] <= detect_set ||
        (status_q[svd_pkg::EV_DETECT_BIT] && !stat_clear_detect);
      status_q[svd_pkg::EV_STABLE_BIT] <= stable_rise ||
        (status_q[svd_pkg::EV_STABLE_BIT] && !stat_read);
    end
  end

  // wake on flag with its enable, regardless of global enable
  assign wake_request = reference_stable_q && detect_flag_q && enables_q[svd_pkg::DETECT_BIT];
  assign irq_vector_request = wake_request && interrupt_control_main_q[svd_pkg::GIE_BIT];
  assign irq = |(status_q & mask_q);

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  // bit 6 reads zero, stable bit shown
  assign ctl_rd = {cfg_q.dir, 1'b0, reference_stable_q, cfg_q.en, cfg_q.level};
  assign flags_rd = flags_other_q | ({7'h00, detect_flag_q} << svd_pkg::DETECT_BIT);
  assign s_axi_arready = !rd_q.valid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // one cycle read answer, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= '0;
    end else if (rd_fire) begin
      rd_q.valid <= 1'b1;
      rd_q.resp <= svd_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        svd_pkg::OFS_CONTROL: rd_q.data <= {24'h000000, ctl_rd};
        svd_pkg::OFS_INTERRUPT_CONTROL_MAIN: rd_q.data <= {24'h000000, interrupt_control_main_q};
        svd_pkg::OFS_FLAGS: rd_q.data <= {24'h000000, flags_rd};
        svd_pkg::OFS_ENABLES: rd_q.data <= {24'h000000, enables_q};
        svd_pkg::OFS_PRIORITY: rd_q.data <= {24'h000000, priority_q};
        svd_pkg::OFS_STATUS: rd_q.data <= {30'h00000000, status_q};
        svd_pkg::OFS_MASK: rd_q.data <= {30'h00000000, mask_q};
        default: begin
          rd_q.data <= 32'h0000_0000;
          rd_q.resp <= svd_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rd_q.valid <= 1'b0;
    end
  end

  assign s_axi_rvalid = rd_q.valid;
  assign s_axi_rdata = rd_q.data;
  assign s_axi_rresp = rd_q.resp;

endmodule : svd_ctrl

// [test/svd_supply_model.sv]
// supply rail model for the detector comparators
// assumes rail steps line up with the sixteen trip levels
`timescale 1ns/1ps
module svd_supply_model (
  // level chosen by the block
  input wire logic [3:0] trip_level_select,
  // rail and external input, in level steps
  input wire logic [3:0] supply_step,
  input wire logic [3:0] ext_step,
  // comparator levels
  output logic cmp_below_internal,
  output logic cmp_below_external
);
  // equal counts as at or below
  assign cmp_below_internal = supply_step <= trip_level_select;
  // external input against a fixed mid reference
  assign cmp_below_external = ext_step <= 4'h7;
endmodule : svd_supply_model

// [test/svd_ctrl_monitor.sv]
// port checker for the supply detect controller
// assumes it is bound into svd_ctrl, one clock domain
`timescale 1ns/1ps
module svd_ctrl_monitor #(
  parameter int SETTLE_CYCLES = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  // detector
  input wire logic [3:0] trip_level_select,
  input wire logic external_trip_select,
  input wire logic detector_power,
  input wire logic wake_request,
  input wire logic irq_vector_request,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] settle_q;
  // cycles since power-up, restarts on every re-enable
  always_ff @(posedge aclk) begin
    if (!aresetn || !detector_power) settle_q <= 16'h0000;
    else if (settle_q != 16'hFFFF) settle_q <= settle_q + 16'h0001;
  end
  a_reset_all_off: assert property (disable iff (1'b0)
    !aresetn |=> !detector_power && trip_level_select == 4'h5 && !irq && !wake_request)
    else $error("detector not off after reset");
  a_ext_route: assert property (external_trip_select == (trip_level_select == 4'hF))
    else $error("external route decode wrong");
  a_settle_hold: assert property (wake_request |-> settle_q >= SETTLE_CYCLES)
    else $error("detect before settle interval");
  a_off_no_wake: assert property (!detector_power ##1 !detector_power |-> !wake_request)
    else $error("wake while detector off");
  a_vector_needs_wake: assert property (irq_vector_request |-> wake_request)
    else $error("vector without wake");
  a_level_by_write: assert property ($changed(trip_level_select) |-> $rose(s_axi_bvalid))
    else $error("level changed without write");
  a_power_by_write: assert property ($changed(detector_power) |-> $rose(s_axi_bvalid))
    else $error("power changed without write");
  // power-off drops wake through the stable bit a cycle later, the flag itself stays
  a_flag_sticky: assert property ($fell(wake_request) && detector_power |-> $rose(s_axi_bvalid))
    else $error("detect dropped without write");
  c_wake: cover property ($rose(wake_request));
  c_irq: cover property ($rose(irq));
  c_ext: cover property (external_trip_select && wake_request);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : svd_ctrl_monitor

// [test/test_svd_ctrl.sv]
// self-checking bench for the supply detect controller
// assumes svd_pkg offsets and the rail model on the comparators
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_svd_ctrl;
  localparam int SETTLE_CYCLES = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, trip_level_select, supply_step = 4'hF, ext_step = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_active = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic cmp_below_internal, cmp_below_external, external_trip_select, detector_power;
  logic wake_request, irq_vector_request, irq;
  // dir, level, rail, external, expected detect
  logic [19:0] rows [9] = '{20'h05301, 20'h05600, 20'h05501, 20'h15611, 20'h15300,
    20'h0F390, 20'h0F321, 20'h00001, 20'h1F0F1};
  int miscompares = 0, cmp_count = 0, cyc = 0;
  svd_ctrl #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_svd_ctrl (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_below_internal,
    .cmp_below_external, .trip_level_select, .external_trip_select, .detector_power,
    .sleep_active, .wake_request, .irq_vector_request, .irq);
  svd_supply_model i_svd_supply_model (.trip_level_select, .supply_step, .ext_step,
    .cmp_below_internal, .cmp_below_external);
  always #12.5 aclk = ~aclk;
  // hang guard, run needs a few hundred cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp; s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK("rdata", e, d)
  endtask : rdc
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(svd_pkg::OFS_CONTROL, 32'h05);
    rdc(svd_pkg::OFS_FLAGS, 32'h00);
    // table: set up in order, then move the rail
    foreach (rows[i]) begin
      supply_step <= rows[i][16] ? 4'h0 : 4'hF;
      ext_step <= rows[i][16] ? 4'h0 : 4'hF;
      sleep_active <= i[0];
      wr(svd_pkg::OFS_CONTROL, {24'h0, rows[i][16], 3'b000, rows[i][15:12]});
      wr(svd_pkg::OFS_CONTROL, {24'h0, rows[i][16], 3'b001, rows[i][15:12]});
      repeat (12) @(posedge aclk);
      wr(svd_pkg::OFS_FLAGS, 32'h0);
      wr(svd_pkg::OFS_ENABLES, 32'h04);
      supply_step <= rows[i][11:8];
      ext_step <= rows[i][7:4];
      repeat (6) @(posedge aclk);
      rdc(svd_pkg::OFS_FLAGS, {29'h0, rows[i][0], 2'b00});
      `CHK("wake", rows[i][0], wake_request)
      `CHK("ext sel", rows[i][15:12] == 4'hF, external_trip_select)
      `CHK("level", rows[i][15:12], trip_level_select)
      `CHK("power", 1'b1, detector_power)
    end
    // trip present at enable, second pass is a re-enable
    for (int k = 0; k < 2; k++) begin
      wr(svd_pkg::OFS_CONTROL, 32'h00);
      wr(svd_pkg::OFS_FLAGS, 32'h00);
      ext_step <= 4'hF;
      wr(svd_pkg::OFS_CONTROL, 32'hFF);
      rdc(svd_pkg::OFS_CONTROL, 32'h9F);
      rdc(svd_pkg::OFS_FLAGS, 32'h00);
      repeat (12) @(posedge aclk);
      rdc(svd_pkg::OFS_CONTROL, 32'hBF);
      rdc(svd_pkg::OFS_FLAGS, 32'h04);
    end
    // interrupt raise, clear on read, mask
    wr(svd_pkg::OFS_MASK, 32'h01);
    `CHK("irq", 1'b1, irq)
    ext_step <= 4'h0;
    repeat (4) @(posedge aclk);
    rdc(svd_pkg::OFS_STATUS, 32'h03);
    @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    wr(svd_pkg::OFS_MASK, 32'h00);
    ext_step <= 4'hF;
    repeat (6) @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    wr(svd_pkg::OFS_MASK, 32'h01);
    `CHK("irq", 1'b1, irq)
    // vector only with global enable
    wr(svd_pkg::OFS_INTERRUPT_CONTROL_MAIN, 32'h80);
    `CHK("vector", 1'b1, irq_vector_request)
    wr(svd_pkg::OFS_INTERRUPT_CONTROL_MAIN, 32'h00);
    `CHK("vector", 1'b0, irq_vector_request)
    // unmapped offset refused
    wr(8'h40, 32'hFF);
    `CHK("bresp", svd_pkg::RESP_SLVERR, r)
    rdc(8'h40, 32'h0);
    `CHK("rresp", svd_pkg::RESP_SLVERR, r)
    // priority storage, cleared again by the reset below
    wr(svd_pkg::OFS_PRIORITY, 32'hA5);
    rdc(svd_pkg::OFS_PRIORITY, 32'hA5);
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("power", 1'b0, detector_power)
    rdc(svd_pkg::OFS_CONTROL, 32'h05);
    rdc(svd_pkg::OFS_PRIORITY, 32'h00);
    conclude();
  end
endmodule : test_svd_ctrl
bind svd_ctrl svd_ctrl_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_svd_ctrl_monitor (.aclk,
  .aresetn, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rresp, .trip_level_select,
  .external_trip_select, .detector_power, .wake_request, .irq_vector_request, .irq);
